// ===== eeprom_div_regs.vh
// Register map, field positions and reset values of the divisor-lock EEPROM controller.

`ifndef EEPROM_DIV_REGS_VH
`define EEPROM_DIV_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// Byte addresses on the register bus.
`define ADDR_W 12
`define CTRL_OFS 12'h000
`define STATUS_OFS 12'h004
`define DIVH_OFS 12'h008
`define DIVL_OFS 12'h00C
`define NVH_OFS 12'h080
`define NVL_OFS 12'h084
`define ARRAY_BASE 12'h100

////////////////////////////////////////////////////////////////////////////////
// Control register fields.
`define CTRL_ERASE_BIT 0
`define CTRL_LATCH_BIT 2
`define CTRL_PUMP_BIT 3

// Status register fields.
`define ST_BUSY_BIT 0
`define ST_PENDING_BIT 1
`define ST_LOCKED_BIT 2
`define ST_REFUSED_BIT 3
`define ST_WAIT_BIT 4
`define ST_STOP_BIT 5
`define ST_ABORTED_BIT 6

// Divisor high register fields.
`define DIVH_LOCKDIS_BIT 7
`define DIVH_FIELD_MSB 2
`define DIV_W 11
`define DIV_HI_W 3

////////////////////////////////////////////////////////////////////////////////
// Values.
`define ERASED_BYTE 8'hFF
`define ZERO_WORD 32'h0000_0000
`define TIMEBASE_US 35
`define PE_TICKS_DEFAULT 16'h0008

`endif

// ===== eeprom_timebase.v
// Timebase prescaler and program/erase duration counter.
`include "eeprom_div_regs.vh"

module eeprom_timebase #(
    parameter TICK_W = 16
) (
    // Clock and reset.
    input wire clk,
    input wire srst,
    // Control.
    input wire run,
    input wire restart,
    input wire [`DIV_W-1:0] divisor,
    input wire [TICK_W-1:0] ticks_needed,
    // Status.
    output reg done
);

    reg [`DIV_W-1:0] pre_reg;
    reg [TICK_W-1:0] tick_reg;
    wire tick;
    wire last_tick;

    // A divisor of zero or one gives a tick on every clock.
    assign tick = run && (pre_reg + 11'h001 >= divisor);
    assign last_tick = (tick_reg + {{(TICK_W-1){1'b0}}, 1'b1} >= ticks_needed);

    always @(posedge clk) begin
        if (srst || restart) begin
            pre_reg <= 11'h000;
            tick_reg <= {TICK_W{1'b0}};
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (run) begin
                if (tick) begin
                    pre_reg <= 11'h000;
                    if (last_tick) begin
                        tick_reg <= {TICK_W{1'b0}};
                        done <= 1'b1;
                    end else begin
                        tick_reg <= tick_reg + {{(TICK_W-1){1'b0}}, 1'b1};
                    end
                end else begin
                    pre_reg <= pre_reg + 11'h001;
                end
            end
        end
    end

endmodule // eeprom_timebase

// ===== eeprom_divider_lock.v
// Byte-erasable EEPROM controller with divisor backing store, divisor lock and low-power handling.
//
// Local design decisions: the address map and register access over APB.
`include "eeprom_div_regs.vh"

module eeprom_divider_lock #(
    parameter DEPTH = 16,
    parameter IDX_W = 4,
    parameter TICK_W = 16,
    parameter [TICK_W-1:0] PE_TICKS = `PE_TICKS_DEFAULT
) (
    // Clock, system reset and power-on reset of the nonvolatile cells.
    input wire clk,
    input wire srst,
    input wire por,
    // APB slave.
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Processor low-power modes.
    input wire wait_mode,
    input wire stop_mode,
    // Analog and timebase controls.
    output wire hv_enable,
    output wire timebase_active,
    output wire [`DIV_W-1:0] timebase_divisor
);

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer states and target kinds.
    localparam [3:0] S_IDLE = 4'b0001;
    localparam [3:0] S_RUN = 4'b0010;
    localparam [3:0] S_WIND = 4'b0100;
    localparam [3:0] S_HALT = 4'b1000;

    localparam [1:0] K_ARRAY = 2'b00;
    localparam [1:0] K_NVH = 2'b01;
    localparam [1:0] K_NVL = 2'b10;

    ////////////////////////////////////////////////////////////////////////////////
    // Address decoding helpers.
    function is_array;
        input [`ADDR_W-1:0] a;
        begin
            is_array = (a >= `ARRAY_BASE) && (a < `ARRAY_BASE + 4 * DEPTH) && (a[1:0] == 2'b00);
        end
    endfunction

    function [IDX_W-1:0] array_index;
        input [`ADDR_W-1:0] a;
        reg [`ADDR_W-1:0] off;
        begin
            off = a - `ARRAY_BASE;
            array_index = off[IDX_W+1:2];
        end
    endfunction

    function is_nv_div;
        input [`ADDR_W-1:0] a;
        begin
            is_nv_div = (a == `NVH_OFS) || (a == `NVL_OFS);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Storage and state.
    reg [7:0] array_mem [0:DEPTH-1];
    reg [7:0] divisor_nv_high;
    reg [7:0] divisor_nv_low;

    reg [`DIV_HI_W-1:0] divisor_high_reg;
    reg [7:0] divisor_low_reg;
    reg divisor_lock_disable;

    reg erase_sel_reg;
    reg bus_latch_bit;
    reg charge_pump_enable;

    reg [3:0] state_reg;
    reg [3:0] state_next;
    reg lat_valid_reg;
    reg [1:0] lat_kind_reg;
    reg [IDX_W-1:0] lat_idx_reg;
    reg [7:0] lat_data_reg;
    reg pending_reg;
    reg refused_reg;
    reg aborted_reg;

    reg [31:0] prdata_reg;
    reg pslverr_reg;
    reg [31:0] rd_next;
    reg err_next;

    wire setup_phase;
    wire wr_access;
    wire lock_armed;
    wire busy;
    wire start_seq;
    wire commit;
    wire seq_done;
    wire timer_run;
    wire timer_restart;
    wire ctrl_wr;
    wire divh_wr;
    wire divl_wr;
    wire div_writable;
    wire latch_wr;
    wire latch_refused;
    wire [7:0] cur_byte;
    wire [7:0] new_byte;
    integer i;

    assign setup_phase = psel && !penable;
    assign wr_access = psel && penable && pwrite;
    assign pready = 1'b1;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;

    // A cleared lock-disable bit arms the lock.
    assign lock_armed = !divisor_lock_disable;
    assign busy = (state_reg != S_IDLE);
    assign timebase_divisor = {divisor_high_reg, divisor_low_reg};

    ////////////////////////////////////////////////////////////////////////////////
    // Register write decoding.
    assign ctrl_wr = wr_access && (paddr == `CTRL_OFS);
    assign divh_wr = wr_access && (paddr == `DIVH_OFS);
    assign divl_wr = wr_access && (paddr == `DIVL_OFS);
    assign div_writable = !bus_latch_bit && !lock_armed;

    // With the buses latched and the sequencer idle, a write to an array byte or to a
    // nonvolatile divisor byte captures the target; the divisor bytes are refused while locked.
    assign latch_wr = wr_access && bus_latch_bit && !busy && (is_array(paddr) || is_nv_div(paddr));
    assign latch_refused = latch_wr && is_nv_div(paddr) && lock_armed;

    ////////////////////////////////////////////////////////////////////////////////
    // Volatile divisor registers and their reload from the nonvolatile bytes.
    always @(posedge clk) begin
        if (srst) begin
            divisor_high_reg <= divisor_nv_high[`DIVH_FIELD_MSB:0];
            divisor_lock_disable <= divisor_nv_high[`DIVH_LOCKDIS_BIT];
            divisor_low_reg <= divisor_nv_low;
        end else begin
            if (divh_wr && div_writable) begin
                divisor_high_reg <= pwdata[`DIVH_FIELD_MSB:0];
                divisor_lock_disable <= pwdata[`DIVH_LOCKDIS_BIT];
            end
            if (divl_wr && div_writable) begin
                divisor_low_reg <= pwdata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control register: the latch cannot drop while the pump is on, so writing both
    // bits to zero clears only the pump and leaves time to remove the high voltage.
    always @(posedge clk) begin
        if (srst) begin
            erase_sel_reg <= 1'b0;
            bus_latch_bit <= 1'b0;
            charge_pump_enable <= 1'b0;
        end else begin
            if (commit) begin
                charge_pump_enable <= 1'b0;
            end
            if (ctrl_wr) begin
                erase_sel_reg <= pwdata[`CTRL_ERASE_BIT];
                bus_latch_bit <= pwdata[`CTRL_LATCH_BIT] || charge_pump_enable;
                charge_pump_enable <= pwdata[`CTRL_PUMP_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Latched target of the next program or erase sequence.
    always @(posedge clk) begin
        if (srst) begin
            lat_valid_reg <= 1'b0;
            lat_kind_reg <= K_ARRAY;
            lat_idx_reg <= {IDX_W{1'b0}};
            lat_data_reg <= 8'h00;
            refused_reg <= 1'b0;
        end else begin
            if (latch_wr && !latch_refused) begin
                lat_valid_reg <= 1'b1;
                lat_kind_reg <= (paddr == `NVH_OFS) ? K_NVH : ((paddr == `NVL_OFS) ? K_NVL : K_ARRAY);
                lat_idx_reg <= array_index(paddr);
                lat_data_reg <= pwdata[7:0];
                refused_reg <= 1'b0;
            end else if (!bus_latch_bit || (busy && state_next == S_IDLE)) begin
                lat_valid_reg <= 1'b0;
            end
            if (latch_refused) begin
                refused_reg <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Program/erase sequencer.
    // A sequence starts only with latch, pump and a captured target; stop blocks it.
    assign start_seq = (state_reg == S_IDLE) && charge_pump_enable && bus_latch_bit && lat_valid_reg
        && !stop_mode;
    assign commit = (state_reg == S_RUN) && seq_done && !stop_mode;

    // Wait mode is deliberately absent from every condition here, so a running
    // sequence keeps counting while the processor waits.
    always @* begin
        state_next = state_reg;
        case (state_reg)
            S_IDLE: begin
                if (start_seq) begin
                    state_next = S_RUN;
                end
            end
            S_RUN: begin
                if (stop_mode && bus_latch_bit && charge_pump_enable) begin
                    state_next = S_HALT;
                end else if (!charge_pump_enable) begin
                    state_next = S_WIND;
                end else if (seq_done) begin
                    state_next = S_IDLE;
                end
            end
            S_WIND: begin
                if (stop_mode || seq_done) begin
                    state_next = S_IDLE;
                end
            end
            S_HALT: begin
                if (!stop_mode) begin
                    state_next = S_RUN;
                end
            end
            default: begin
                state_next = S_IDLE;
            end
        endcase
    end

    always @(posedge clk) begin
        if (srst) begin
            state_reg <= S_IDLE;
            pending_reg <= 1'b0;
            aborted_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (state_reg == S_RUN && state_next == S_HALT) begin
                pending_reg <= 1'b1;
            end else if (commit) begin
                pending_reg <= 1'b0;
            end
            // An unfinished sequence leaves the byte in doubt; the flag holds until the next start.
            if (state_reg == S_WIND && state_next == S_IDLE) begin
                aborted_reg <= 1'b1;
            end else if (start_seq) begin
                aborted_reg <= 1'b0;
            end
        end
    end

    // Stop freezes the timebase; leaving a halt restarts the timing from zero.
    assign timer_run = (state_reg == S_RUN || state_reg == S_WIND) && !stop_mode;
    assign timer_restart = start_seq || (state_reg == S_HALT && !stop_mode);
    assign timebase_active = timer_run;
    assign hv_enable = (state_reg == S_RUN) && charge_pump_enable && bus_latch_bit && lat_valid_reg
        && !stop_mode;

    eeprom_timebase #(
        .TICK_W(TICK_W)
    ) u_timebase (
        .clk(clk),
        .srst(srst),
        .run(timer_run),
        .restart(timer_restart),
        .divisor(timebase_divisor),
        .ticks_needed(PE_TICKS),
        .done(seq_done)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Nonvolatile cells: array bytes and divisor bytes share one commit path.
    assign cur_byte = (lat_kind_reg == K_NVH) ? divisor_nv_high :
        ((lat_kind_reg == K_NVL) ? divisor_nv_low : array_mem[lat_idx_reg]);
    assign new_byte = erase_sel_reg ? `ERASED_BYTE : (cur_byte & lat_data_reg);

    always @(posedge clk) begin
        if (por) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                array_mem[i] <= `ERASED_BYTE;
            end
            divisor_nv_high <= `ERASED_BYTE;
            divisor_nv_low <= `ERASED_BYTE;
        end else if (commit) begin
            if (lat_kind_reg == K_NVH) begin
                divisor_nv_high <= new_byte;
            end else if (lat_kind_reg == K_NVL) begin
                divisor_nv_low <= new_byte;
            end else begin
                array_mem[lat_idx_reg] <= new_byte;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read decoding, registered in the setup phase so data stands for the access phase.
    always @* begin
        rd_next = `ZERO_WORD;
        err_next = 1'b0;
        if (paddr == `CTRL_OFS) begin
            rd_next[`CTRL_ERASE_BIT] = erase_sel_reg;
            rd_next[`CTRL_LATCH_BIT] = bus_latch_bit;
            rd_next[`CTRL_PUMP_BIT] = charge_pump_enable;
        end else if (paddr == `STATUS_OFS) begin
            rd_next[`ST_BUSY_BIT] = busy;
            rd_next[`ST_PENDING_BIT] = pending_reg;
            rd_next[`ST_LOCKED_BIT] = lock_armed;
            rd_next[`ST_REFUSED_BIT] = refused_reg;
            rd_next[`ST_WAIT_BIT] = wait_mode;
            rd_next[`ST_STOP_BIT] = stop_mode;
            rd_next[`ST_ABORTED_BIT] = aborted_reg;
        end else if (paddr == `DIVH_OFS) begin
            rd_next[`DIVH_LOCKDIS_BIT] = divisor_lock_disable;
            rd_next[`DIVH_FIELD_MSB:0] = divisor_high_reg;
        end else if (paddr == `DIVL_OFS) begin
            rd_next[7:0] = divisor_low_reg;
        end else if (is_nv_div(paddr) || is_array(paddr)) begin
            if (pending_reg) begin
                err_next = 1'b1;
            end else if (paddr == `NVH_OFS) begin
                rd_next[7:0] = divisor_nv_high;
            end else if (paddr == `NVL_OFS) begin
                rd_next[7:0] = divisor_nv_low;
            end else begin
                rd_next[7:0] = array_mem[array_index(paddr)];
            end
        end else begin
            err_next = 1'b1;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            prdata_reg <= `ZERO_WORD;
            pslverr_reg <= 1'b0;
        end else if (setup_phase) begin
            prdata_reg <= pwrite ? `ZERO_WORD : rd_next;
            pslverr_reg <= err_next;
        end
    end

endmodule // eeprom_divider_lock

// ===== eeprom_divider_lock_checker.sv
// Port-level checker of the divisor-lock controller, bound into its top module.
`include "eeprom_div_regs.vh"
module eeprom_divider_lock_checker #(
    parameter DEPTH = 16
) (
    input wire clk,
    input wire srst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`ADDR_W-1:0] paddr,
    input wire [31:0] prdata,
    input wire pslverr,
    input wire wait_mode,
    input wire stop_mode,
    input wire hv_enable,
    input wire timebase_active,
    input wire [`DIV_W-1:0] timebase_divisor
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    logic stop_q, hv_q, pend, div_wr_q;
    wire setup_rd = psel && !penable && !pwrite;
    wire reg_hit = paddr == `CTRL_OFS || paddr == `STATUS_OFS || paddr == `DIVH_OFS || paddr == `DIVL_OFS;
    wire nv_hit = paddr == `NVH_OFS || paddr == `NVL_OFS;
    wire in_arr = paddr >= `ARRAY_BASE && paddr < `ARRAY_BASE + 4 * DEPTH && paddr[1:0] == 2'h0;
    wire ctrl_wr = psel && penable && pwrite && paddr == `CTRL_OFS;
    ////////////////////////////////////////////////////////////////////////////////
    // Tracks a sequence halted by stop until its restart has committed.
    // Stop cuts the high voltage in the same cycle, so entry is judged on last cycle's value.
    always_ff @(posedge clk) begin
        stop_q <= stop_mode;
        hv_q <= hv_enable;
        div_wr_q <= psel && penable && pwrite && (paddr == `DIVH_OFS || paddr == `DIVL_OFS);
        if (srst) begin
            pend <= 1'b0;
        end else if (stop_mode && !stop_q && hv_q) begin
            pend <= 1'b1;
        end else if (hv_q && !hv_enable && !stop_mode) begin
            pend <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_stop_cuts_hv: assert property (stop_mode && !stop_q && hv_q |=> !hv_enable && !timebase_active)
        else $error("high voltage stayed on after stop entry");
    a_stop_idles: assert property (stop_mode && stop_q |-> !hv_enable && !timebase_active)
        else $error("pump or timebase active in stop");
    a_restart_auto: assert property (pend && stop_q && !stop_mode |-> ##[1:3] hv_enable)
        else $error("halted sequence did not restart");
    a_array_denied: assert property (pend && (hv_enable || stop_mode) && setup_rd && (in_arr || nv_hit)
        |=> pslverr && prdata == `ZERO_WORD)
        else $error("array read allowed during restart");
    a_hv_timed: assert property (hv_enable |-> timebase_active)
        else $error("high voltage without timebase");
    a_divisor_hold: assert property ($changed(timebase_divisor) |-> div_wr_q)
        else $error("divisor changed without a divisor write");
    a_div_readable: assert property (setup_rd && reg_hit |=> !pslverr)
        else $error("register read refused");
    a_wait_runs: assert property (wait_mode && !stop_mode && hv_enable && !ctrl_wr |=> hv_enable || !timebase_active)
        else $error("wait mode disturbed a sequence");
    a_unmapped_err: assert property (psel && !penable && !(reg_hit || nv_hit || in_arr) |=> pslverr && prdata == `ZERO_WORD)
        else $error("unmapped access not flagged");
    a_upper_zero: assert property (psel && penable |-> prdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    c_restart: cover property (pend && !stop_mode && hv_enable);
    c_wait_seq: cover property (wait_mode && hv_enable);
    c_stop_halt: cover property (stop_mode && hv_q);
    c_error: cover property (psel && penable && pslverr);
endmodule // eeprom_divider_lock_checker

bind eeprom_divider_lock eeprom_divider_lock_checker #(.DEPTH(DEPTH)) eeprom_divider_lock_checker_inst (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pslverr(pslverr), .wait_mode(wait_mode), .stop_mode(stop_mode), .hv_enable(hv_enable),
    .timebase_active(timebase_active), .timebase_divisor(timebase_divisor));

// ===== eeprom_divider_lock_test.sv
// Testbench of the divisor-lock controller: registers, sequences, low-power modes and lock.
`include "eeprom_div_regs.vh"
module eeprom_divider_lock_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic por = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, wait_mode = 1'b0, stop_mode = 1'b0;
    logic [`ADDR_W-1:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] rd_val;
    logic rd_err;
    wire [31:0] prdata;
    wire pready, pslverr, hv_enable, timebase_active;
    wire [`DIV_W-1:0] timebase_divisor;
    wire [31:0] div = {21'h000000, timebase_divisor};
    int mismatches = 0;
    int checked = 0;
    always #12.5 clk = ~clk;
    eeprom_divider_lock #(.PE_TICKS(16'h0002)) eeprom_divider_lock_inst (.clk(clk), .srst(srst), .por(por),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .wait_mode(wait_mode), .stop_mode(stop_mode), .hv_enable(hv_enable),
        .timebase_active(timebase_active), .timebase_divisor(timebase_divisor));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    // One APB transfer; read data and error are taken at the edge that sees pready.
    // It returns one edge later, so that callers see the settled result of the transfer.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd_val = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic start(input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
        apb(1'b1, `CTRL_OFS, 32'h0000_0004 | e);
        apb(1'b1, a, d);
        apb(1'b1, `CTRL_OFS, 32'h0000_000C | e);
    endtask
    task automatic finish();
        int i;
        rd_val = 32'h0000_0001;
        for (i = 0; i < 400 && rd_val[`ST_BUSY_BIT] !== 1'b0; i++) apb(1'b0, `STATUS_OFS, `ZERO_WORD);
        chk_bit(rd_val[`ST_BUSY_BIT], 1'b0);
        apb(1'b1, `CTRL_OFS, `ZERO_WORD);
    endtask
    task automatic wait_hv();
        int i;
        for (i = 0; i < 60 && hv_enable !== 1'b1; i++) @(posedge clk);
        chk_bit(hv_enable, 1'b1);
    endtask
    task automatic sys_reset();
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #500000;
        mismatches++;
        wrap_up();
    end
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        por <= 1'b0;
        apb(1'b0, `DIVH_OFS, `ZERO_WORD);
        chk_val(rd_val & 32'h87, 32'h0000_0087);
        chk_val(div, 32'h0000_07FF);
        apb(1'b0, 12'h010, `ZERO_WORD);
        chk_bit(rd_err, 1'b1);
        apb(1'b0, `STATUS_OFS, `ZERO_WORD);
        chk_val(rd_val, `ZERO_WORD);
        apb(1'b1, `DIVH_OFS, 32'h0000_0080);
        apb(1'b1, `DIVL_OFS, 32'h0000_0008);
        chk_val(div, 32'h0000_0008);
        apb(1'b1, `CTRL_OFS, 32'h0000_0004);
        apb(1'b1, `DIVL_OFS, 32'h0000_0005);
        chk_val(div, 32'h0000_0008);
        wait_mode <= 1'b1;
        start(`ARRAY_BASE, 32'h0000_005A, `ZERO_WORD);
        wait_hv();
        chk_bit(hv_enable, 1'b1);
        finish();
        wait_mode <= 1'b0;
        apb(1'b0, `ARRAY_BASE, `ZERO_WORD);
        chk_val(rd_val, 32'h0000_005A);
        start(`ARRAY_BASE, `ZERO_WORD, 32'h0000_0001);
        finish();
        apb(1'b0, `ARRAY_BASE, `ZERO_WORD);
        chk_val(rd_val, 32'h0000_00FF);
        start(`ARRAY_BASE + 12'h004, 32'h0000_0033, `ZERO_WORD);
        wait_hv();
        stop_mode <= 1'b1;
        repeat (3) @(posedge clk);
        chk_bit(hv_enable, 1'b0);
        chk_bit(timebase_active, 1'b0);
        apb(1'b0, `STATUS_OFS, `ZERO_WORD);
        chk_val(rd_val & 32'h22, 32'h0000_0022);
        stop_mode <= 1'b0;
        apb(1'b0, `ARRAY_BASE + 12'h004, `ZERO_WORD);
        chk_bit(rd_err, 1'b1);
        finish();
        apb(1'b0, `STATUS_OFS, `ZERO_WORD);
        chk_val(rd_val & 32'h02, `ZERO_WORD);
        apb(1'b0, `ARRAY_BASE + 12'h004, `ZERO_WORD);
        chk_val(rd_val, 32'h0000_0033);
        start(`ARRAY_BASE + 12'h008, 32'h0000_0011, `ZERO_WORD);
        wait_hv();
        apb(1'b1, `CTRL_OFS, 32'h0000_0004);
        stop_mode <= 1'b1;
        repeat (2) @(posedge clk);
        stop_mode <= 1'b0;
        apb(1'b0, `STATUS_OFS, `ZERO_WORD);
        chk_val(rd_val & 32'h43, 32'h0000_0040);
        apb(1'b1, `CTRL_OFS, `ZERO_WORD);
        apb(1'b0, `ARRAY_BASE + 12'h008, `ZERO_WORD);
        chk_val(rd_val, 32'h0000_00FF);
        start(`NVH_OFS, 32'h0000_007F, `ZERO_WORD);
        finish();
        start(`NVL_OFS, 32'h0000_0008, `ZERO_WORD);
        finish();
        sys_reset();
        apb(1'b0, `DIVH_OFS, `ZERO_WORD);
        chk_val(rd_val & 32'h87, 32'h0000_0007);
        chk_val(div, 32'h0000_0708);
        apb(1'b0, `STATUS_OFS, `ZERO_WORD);
        chk_val(rd_val & 32'h04, 32'h0000_0004);
        apb(1'b1, `DIVL_OFS, 32'h0000_0001);
        apb(1'b1, `DIVH_OFS, 32'h0000_0080);
        chk_val(div, 32'h0000_0708);
        apb(1'b0, `DIVH_OFS, `ZERO_WORD);
        chk_val(rd_val & 32'h80, `ZERO_WORD);
        start(`NVL_OFS, `ZERO_WORD, `ZERO_WORD);
        apb(1'b0, `STATUS_OFS, `ZERO_WORD);
        chk_val(rd_val & 32'h09, 32'h0000_0008);
        apb(1'b1, `CTRL_OFS, `ZERO_WORD);
        sys_reset();
        apb(1'b0, `NVL_OFS, `ZERO_WORD);
        chk_val(rd_val, 32'h0000_0008);
        chk_val(div, 32'h0000_0708);
        wrap_up();
    end
endmodule // eeprom_divider_lock_test
